/* File: include/dms_regs.svh */
`ifndef DMS_REGS_SVH
`define DMS_REGS_SVH

// Special function register addresses
`define DMS_ADDR_P0_LOW     8'h82
`define DMS_ADDR_P0_HIGH    8'h83
`define DMS_ADDR_P1_LOW     8'h84
`define DMS_ADDR_P1_HIGH    8'h85
`define DMS_ADDR_PSEL       8'h86
`define DMS_ADDR_CLKCTL     8'h8E

// Field positions and reset values
`define DMS_STRETCH_LSB     0
`define DMS_STRETCH_MSB     2
`define DMS_PSEL_BIT        0
`define DMS_CLKCTL_RESET    8'h01
`define DMS_PSEL_RESET      8'h00
`define DMS_PTR_RESET       16'h0000

// Timing counts in oscillator clocks; DMS_BASE_MC counts machine cycles
`define DMS_CLK_PER_MC      4
`define DMS_BASE_MC         2
`define DMS_STROBE_ZERO     2
`define DMS_STROBE_STEP     4

`endif

/* File: include/dms_pkg.sv */
package dms_pkg;

    typedef enum logic [2:0] {
        DMS_IDLE   = 3'b000,
        DMS_ADDR   = 3'b001,
        DMS_STROBE = 3'b011,
        DMS_HOLD   = 3'b010
    } dms_state_t;

    typedef logic [2:0]  dms_stretch_t;
    typedef logic [15:0] dms_ptr_t;

endpackage

/* File: rtl/dms_mc_timer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dms_regs.svh"

module dms_mc_timer
    import dms_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    output var  logic mc_tick_o
);

    logic [1:0] phase;
    logic [1:0] next_phase;
    logic       next_tick;

    always_comb begin
        next_phase = phase + 2'd1;
        next_tick  = (phase == 2'(`DMS_CLK_PER_MC - 1));
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            phase     <= 2'd0;
            mc_tick_o <= 1'b0;
        end else begin
            phase     <= next_phase;
            mc_tick_o <= next_tick;
        end
    end

endmodule // dms_mc_timer

`default_nettype wire

/* File: rtl/dms_xmem_unit.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dms_regs.svh"

module dms_xmem_unit
    import dms_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       sys_rst_i,
    // Special function register port from the core
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    output var  logic [7:0] sfr_rdata_o,
    // Pointer instructions
    input  wire logic       ptr_load_i,
    input  wire logic [15:0] ptr_load_val_i,
    input  wire logic       ptr_inc_i,
    input  wire logic       psel_inc_i,
    output var  logic [15:0] data_pointer_o,
    // External data move request
    input  wire logic       xmove_req_i,
    input  wire logic       xmove_write_i,
    input  wire logic       xmove_use_ptr_i,
    input  wire logic [7:0] xmove_ri_addr_i,
    input  wire logic [7:0] xmove_wdata_i,
    output var  logic       core_stall_o,
    output var  logic       xmove_done_o,
    output var  logic [7:0] xmove_rdata_o,
    // External bus pins
    input  wire logic [7:0] addr_data_mux_port_i,
    output var  logic [7:0] addr_data_mux_port_o,
    output var  logic       addr_data_mux_port_oe_n_o,
    output var  logic [7:0] high_address_port_o,
    output var  logic       addr_latch_o,
    output var  logic       rd_strobe_n_o,
    output var  logic       wr_strobe_n_o
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] clock_control_reg;
    logic [7:0] next_clock_control_reg;
    logic       pointer_select;
    logic       next_pointer_select;
    dms_ptr_t   pointer_zero;
    dms_ptr_t   pointer_one;
    dms_ptr_t   next_pointer_zero;
    dms_ptr_t   next_pointer_one;
    dms_ptr_t   active_ptr;
    logic       mc_tick;

    // Bus pins pass three flops; a change counts once stages two and three agree
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_s3;
    logic [7:0] pin_val;
    logic [7:0] next_pin_val;

    function automatic logic [7:0] sfr_read(input logic [7:0] a, input logic [7:0] ck,
                                            input logic ps, input dms_ptr_t p0,
                                            input dms_ptr_t p1);
        case (a)
            `DMS_ADDR_P0_LOW:  sfr_read = p0[7:0];
            `DMS_ADDR_P0_HIGH: sfr_read = p0[15:8];
            `DMS_ADDR_P1_LOW:  sfr_read = p1[7:0];
            `DMS_ADDR_P1_HIGH: sfr_read = p1[15:8];
            `DMS_ADDR_PSEL:    sfr_read = {7'h00, ps};
            `DMS_ADDR_CLKCTL:  sfr_read = ck;
            default:           sfr_read = 8'h00;
        endcase
    endfunction

    assign active_ptr = pointer_select ? pointer_one : pointer_zero;

    always_comb begin
        next_clock_control_reg = clock_control_reg;
        next_pointer_select    = pointer_select;
        next_pointer_zero      = pointer_zero;
        next_pointer_one       = pointer_one;
        if (sfr_wr_i) begin
            case (sfr_addr_i)
                `DMS_ADDR_CLKCTL:  next_clock_control_reg = sfr_wdata_i;
                `DMS_ADDR_PSEL:    next_pointer_select = sfr_wdata_i[`DMS_PSEL_BIT];
                `DMS_ADDR_P0_LOW:  next_pointer_zero[7:0] = sfr_wdata_i;
                `DMS_ADDR_P0_HIGH: next_pointer_zero[15:8] = sfr_wdata_i;
                `DMS_ADDR_P1_LOW:  next_pointer_one[7:0] = sfr_wdata_i;
                `DMS_ADDR_P1_HIGH: next_pointer_one[15:8] = sfr_wdata_i;
                default: ;
            endcase
        end
        if (psel_inc_i) begin
            next_pointer_select = ~pointer_select;
        end
        if (ptr_load_i || ptr_inc_i) begin
            if (pointer_select) begin
                next_pointer_one = ptr_load_i ? ptr_load_val_i : pointer_one + 16'h0001;
            end else begin
                next_pointer_zero = ptr_load_i ? ptr_load_val_i : pointer_zero + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            clock_control_reg <= `DMS_CLKCTL_RESET;
            pointer_select    <= 1'b0;
            pointer_zero      <= `DMS_PTR_RESET;
            pointer_one       <= `DMS_PTR_RESET;
            sfr_rdata_o       <= 8'h00;
            data_pointer_o    <= `DMS_PTR_RESET;
        end else begin
            clock_control_reg <= next_clock_control_reg;
            pointer_select    <= next_pointer_select;
            pointer_zero      <= next_pointer_zero;
            pointer_one       <= next_pointer_one;
            sfr_rdata_o       <= sfr_read(sfr_addr_i, next_clock_control_reg,
                                          next_pointer_select, next_pointer_zero,
                                          next_pointer_one);
            data_pointer_o    <= pointer_select ? next_pointer_one : next_pointer_zero;
        end
    end

    // ------------------------------------------------------------
    // Machine cycle timing and bus pin synchronizer
    // ------------------------------------------------------------
    dms_mc_timer u_mc_timer (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .mc_tick_o  (mc_tick)
    );

    always_comb begin
        next_pin_val = pin_val;
        if (pin_s2 == pin_s3) begin
            next_pin_val = pin_s3;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pin_s1  <= 8'h00;
            pin_s2  <= 8'h00;
            pin_s3  <= 8'h00;
            pin_val <= 8'h00;
        end else begin
            pin_s1  <= addr_data_mux_port_i;
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            pin_val <= next_pin_val;
        end
    end

    // ------------------------------------------------------------
    // External data move sequencer
    // ------------------------------------------------------------
    // Address phase is one clock, then the strobe, then hold to the end of the
    // stretched cycle count. Stretch is latched at start so a mid-move write
    // only affects the next move.
    dms_state_t  state;
    dms_state_t  next_state;
    logic [5:0]  clk_cnt;
    logic [5:0]  next_clk_cnt;
    logic [5:0]  strobe_len;
    logic [5:0]  next_strobe_len;
    logic [5:0]  total_len;
    logic [5:0]  next_total_len;
    logic        is_write;
    logic        next_is_write;
    logic [15:0] xaddr;
    logic [15:0] next_xaddr;
    logic [7:0]  wdata;
    logic [7:0]  next_wdata;
    logic [7:0]  next_rdata;
    logic        next_done;
    logic        next_ale;
    logic        next_rd_n;
    logic        next_wr_n;
    logic        next_oe_n;
    logic [7:0]  next_p0;
    dms_stretch_t st;

    assign st = clock_control_reg[`DMS_STRETCH_MSB:`DMS_STRETCH_LSB];

    always_comb begin
        next_state      = state;
        next_clk_cnt    = clk_cnt + 6'd1;
        next_strobe_len = strobe_len;
        next_total_len  = total_len;
        next_is_write   = is_write;
        next_xaddr      = xaddr;
        next_wdata      = wdata;
        next_rdata      = xmove_rdata_o;
        next_done       = 1'b0;
        next_ale        = 1'b0;
        next_rd_n       = 1'b1;
        next_wr_n       = 1'b1;
        next_oe_n       = 1'b1;
        next_p0         = addr_data_mux_port_o;
        case (state)
            DMS_IDLE: begin
                next_clk_cnt = 6'd0;
                // Start aligned to machine cycle boundary; program fetch untouched
                if (xmove_req_i && mc_tick) begin
                    next_state      = DMS_ADDR;
                    next_is_write   = xmove_write_i;
                    next_xaddr      = xmove_use_ptr_i ? active_ptr : {8'h00, xmove_ri_addr_i};
                    next_wdata      = xmove_wdata_i;
                    next_total_len  = 6'((`DMS_BASE_MC + st) * `DMS_CLK_PER_MC);
                    next_strobe_len = (st == 3'd0) ? 6'(`DMS_STROBE_ZERO) :
                                      6'(st * `DMS_STROBE_STEP);
                    next_ale        = 1'b1;
                    next_oe_n       = 1'b0;
                    next_p0         = next_xaddr[7:0];
                end
            end
            DMS_ADDR: begin
                next_state = DMS_STROBE;
                next_rd_n  = is_write;
                next_wr_n  = ~is_write;
                next_oe_n  = ~is_write;
                next_p0    = wdata;
            end
            DMS_STROBE: begin
                next_rd_n = is_write;
                next_wr_n = ~is_write;
                next_oe_n = ~is_write;
                if (clk_cnt == strobe_len) begin
                    next_state = DMS_HOLD;
                    next_rd_n  = 1'b1;
                    next_wr_n  = 1'b1;
                end
            end
            DMS_HOLD: begin
                next_oe_n = ~is_write;
                // Synced pin lags four clocks; keep the last two strobe-low samples
                if (!is_write && (clk_cnt == strobe_len + 6'd3)) begin
                    next_rdata = pin_val;
                end
                if (clk_cnt >= total_len - 6'd1) begin
                    next_state = DMS_IDLE;
                    next_done  = 1'b1;
                    next_oe_n  = 1'b1;
                end
            end
            default: next_state = DMS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state                     <= DMS_IDLE;
            clk_cnt                   <= 6'd0;
            strobe_len                <= 6'd0;
            total_len                 <= 6'd0;
            is_write                  <= 1'b0;
            xaddr                     <= 16'h0000;
            wdata                     <= 8'h00;
            xmove_rdata_o             <= 8'h00;
            xmove_done_o              <= 1'b0;
            core_stall_o              <= 1'b0;
            addr_latch_o              <= 1'b0;
            rd_strobe_n_o             <= 1'b1;
            wr_strobe_n_o             <= 1'b1;
            addr_data_mux_port_oe_n_o <= 1'b1;
            addr_data_mux_port_o      <= 8'h00;
            high_address_port_o       <= 8'h00;
        end else begin
            state                     <= next_state;
            clk_cnt                   <= next_clk_cnt;
            strobe_len                <= next_strobe_len;
            total_len                 <= next_total_len;
            is_write                  <= next_is_write;
            xaddr                     <= next_xaddr;
            wdata                     <= next_wdata;
            xmove_rdata_o             <= next_rdata;
            xmove_done_o              <= next_done;
            core_stall_o              <= (next_state != DMS_IDLE);
            addr_latch_o              <= next_ale;
            rd_strobe_n_o             <= next_rd_n;
            wr_strobe_n_o             <= next_wr_n;
            addr_data_mux_port_oe_n_o <= next_oe_n;
            addr_data_mux_port_o      <= next_p0;
            high_address_port_o       <= next_xaddr[15:8];
        end
    end

endmodule // dms_xmem_unit

`default_nettype wire

/* File: sim/dms_xmem_unit_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dms_regs.svh"

module dms_xmem_unit_chk (
    input wire logic       core_clk_i,
    input wire logic       sys_rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic       core_stall_o,
    input wire logic       xmove_done_o,
    input wire logic       addr_data_mux_port_oe_n_o,
    input wire logic [7:0] high_address_port_o,
    input wire logic       addr_latch_o,
    input wire logic       rd_strobe_n_o,
    input wire logic       wr_strobe_n_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_len; $rose(core_stall_o) |-> ##[7:37] xmove_done_o; endproperty
    a_len: assert property (p_len) else $error("move length out of range");
    property p_rmax; $fell(rd_strobe_n_o) |-> ##[1:28] $rose(rd_strobe_n_o); endproperty
    a_rmax: assert property (p_rmax) else $error("read strobe too long");
    property p_wmin; $fell(wr_strobe_n_o) |=> !wr_strobe_n_o; endproperty
    a_wmin: assert property (p_wmin) else $error("write strobe too short");
    property p_excl; rd_strobe_n_o || wr_strobe_n_o; endproperty
    a_excl: assert property (p_excl) else $error("both strobes low");
    property p_ale; $rose(core_stall_o) |-> addr_latch_o; endproperty
    a_ale: assert property (p_ale) else $error("no latch pulse at start");
    property p_alep; addr_latch_o |=> !addr_latch_o; endproperty
    a_alep: assert property (p_alep) else $error("latch pulse too long");
    property p_rdz; !rd_strobe_n_o |-> addr_data_mux_port_oe_n_o; endproperty
    a_rdz: assert property (p_rdz) else $error("bus driven during read");
    property p_wrd; !wr_strobe_n_o |-> !addr_data_mux_port_oe_n_o; endproperty
    a_wrd: assert property (p_wrd) else $error("bus released during write");
    property p_hold; core_stall_o && $past(core_stall_o) |-> $stable(high_address_port_o);
    endproperty
    a_hold: assert property (p_hold) else $error("high address moved");
    property p_done; xmove_done_o |-> rd_strobe_n_o && wr_strobe_n_o ##1 !xmove_done_o;
    endproperty
    a_done: assert property (p_done) else $error("bad done pulse");
    property p_psel; $past(sfr_addr_i) == `DMS_ADDR_PSEL |-> sfr_rdata_o[7:1] == 7'h00;
    endproperty
    a_psel: assert property (p_psel) else $error("select upper bits set");
endmodule // dms_xmem_unit_chk

bind dms_xmem_unit dms_xmem_unit_chk u_chk (
    .core_clk_i, .sys_rst_i, .sfr_addr_i, .sfr_rdata_o, .core_stall_o, .xmove_done_o,
    .addr_data_mux_port_oe_n_o, .high_address_port_o, .addr_latch_o, .rd_strobe_n_o,
    .wr_strobe_n_o
);

`default_nettype wire

/* File: sim/dms_xram_model.sv */
`timescale 1ns/100ps
`default_nettype none

module dms_xram_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] bus_i,
    input  wire logic [7:0] high_i,
    input  wire logic       latch_i,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    input  wire logic [4:0] delay_i,
    output var  logic [7:0] bus_o
);
    logic [7:0]  mem [0:65535];
    logic [15:0] addr;
    logic [7:0]  last     = 8'h00;
    int          wait_cnt = 0;

    always @(posedge clk_i) begin
        last     <= bus_i;
        wait_cnt <= rd_n_i ? 0 : wait_cnt + 1;
        if (latch_i)
            addr <= {high_i, bus_i};
        if (!wr_n_i)
            mem[addr] <= bus_i;
    end

    // Released bus toggles, so a late sample never sees a held value
    assign bus_o = (!rd_n_i && wait_cnt >= int'(delay_i)) ? mem[addr] : ~last;
endmodule // dms_xram_model

`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dms_regs.svh"

module tb_top;
    logic        clk, rst, swr, ld, inc, psi, xreq, xw, xp, oe_n, ale, rd_n, wr_n, stall, done;
    logic [7:0]  sa, sd, srd, ri, wd, p0_o, hi, xrd, mdl, bus;
    logic [15:0] ld_val, dp;
    logic [4:0]  dly;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc       = 0;

    assign bus = oe_n ? mdl : p0_o;

    dms_xmem_unit u_dut (
        .core_clk_i(clk), .sys_rst_i(rst), .sfr_addr_i(sa), .sfr_wr_i(swr),
        .sfr_wdata_i(sd), .sfr_rdata_o(srd), .ptr_load_i(ld), .ptr_load_val_i(ld_val),
        .ptr_inc_i(inc), .psel_inc_i(psi), .data_pointer_o(dp), .xmove_req_i(xreq),
        .xmove_write_i(xw), .xmove_use_ptr_i(xp), .xmove_ri_addr_i(ri), .xmove_wdata_i(wd),
        .core_stall_o(stall), .xmove_done_o(done), .xmove_rdata_o(xrd),
        .addr_data_mux_port_i(bus), .addr_data_mux_port_o(p0_o),
        .addr_data_mux_port_oe_n_o(oe_n), .high_address_port_o(hi), .addr_latch_o(ale),
        .rd_strobe_n_o(rd_n), .wr_strobe_n_o(wr_n)
    );

    dms_xram_model u_ram (
        .clk_i(clk), .bus_i(bus), .high_i(hi), .latch_i(ale), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .delay_i(dly), .bus_o(mdl)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            $display("ERROR %0t run timed out", $time);
            summarize();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sa  <= a;
        sd  <= d;
        swr <= 1'b1;
        @(posedge clk);
        swr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sa <= a;
        @(posedge clk);
        @(negedge clk);
        chk({8'h00, srd}, {8'h00, exp});
    endtask

    task automatic op(input int k);
        @(posedge clk);
        ld  <= (k == 0);
        inc <= (k == 1);
        psi <= (k == 2);
        @(posedge clk);
        {ld, inc, psi} <= 3'b000;
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic xmove(input logic w, input logic p, input logic [7:0] r,
                         input logic [7:0] d, input int st, input logic [15:0] ad,
                         input logic [7:0] exp);
        int n  = 0;
        int lo = 0;
        int sc = 0;
        @(posedge clk);
        xreq <= 1'b1;
        xw   <= w;
        xp   <= p;
        ri   <= r;
        wd   <= d;
        do begin
            @(negedge clk);
            n++;
            sc += int'(stall === 1'b1);
            lo += int'((w ? wr_n : rd_n) === 1'b0);
            if (ale === 1'b1)
                chk({hi, p0_o}, ad);
        end while (done !== 1'b1 && n < 80);
        chk(16'(sc >= (2 + st) * 4 - 1 && sc <= (2 + st) * 4 + 1), 16'h0001);
        chk(16'(lo), 16'(st == 0 ? 2 : 4 * st));
        if (!w)
            chk({8'h00, xrd}, {8'h00, exp});
        // Drop the request one clock after done; the next tick is three clocks off
        @(posedge clk);
        xreq <= 1'b0;
    endtask

    task automatic t_reset();
        rreg(`DMS_ADDR_CLKCTL, 8'h01);
        rreg(`DMS_ADDR_PSEL, 8'h00);
        rreg(8'h8F, 8'h00);
        chk(dp, 16'h0000);
        $display("reset defaults test done");
    endtask

    task automatic t_pointers();
        for (int i = 0; i < 4; i++)
            wreg(8'h82 + 8'(i), 8'h11 * 8'(i + 1));
        for (int i = 0; i < 4; i++)
            rreg(8'h82 + 8'(i), 8'h11 * 8'(i + 1));
        chk(dp, 16'h2211);
        wreg(`DMS_ADDR_PSEL, 8'hFF);
        rreg(`DMS_ADDR_PSEL, 8'h01);
        chk(dp, 16'h4433);
        op(1);
        chk(dp, 16'h4434);
        rreg(8'h82, 8'h11);
        op(2);
        chk(dp, 16'h2211);
        op(0);
        chk(dp, 16'hBEEF);
        rreg(8'h85, 8'h44);
        $display("pointer test done");
    endtask

    task automatic t_stretch();
        for (int s = 0; s < 8; s++) begin
            wreg(`DMS_ADDR_CLKCTL, 8'(s));
            rreg(`DMS_ADDR_CLKCTL, 8'(s));
            dly <= 5'(s > 1 ? 4 * s - 5 : 0);
            xmove(1'b1, 1'b1, 8'h00, 8'hA0 + 8'(s), s, 16'hBEEF, 8'h00);
            xmove(1'b0, 1'b1, 8'h00, 8'h00, s, 16'hBEEF, 8'hA0 + 8'(s));
        end
        $display("stretch test done");
    endtask

    task automatic t_ri();
        dly <= 5'd0;
        wreg(`DMS_ADDR_CLKCTL, 8'h02);
        xmove(1'b1, 1'b0, 8'h3C, 8'h5A, 2, 16'h003C, 8'h00);
        xmove(1'b0, 1'b0, 8'h3C, 8'h00, 2, 16'h003C, 8'h5A);
        $display("indirect address test done");
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        {rst, swr, ld, inc, psi, xreq, xw, xp} = 8'h80;
        {sa, sd, ri, wd} = 32'h0000_0000;
        ld_val = 16'hBEEF;
        dly    = 5'd0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pointers();
        t_stretch();
        t_ri();
        summarize();
    end
endmodule // tb_top

`default_nettype wire
